// *** ctr_cap_src.sv ***
`timescale 1ns/1ps
module ctr_cap_src #(
    parameter logic [ctr_pkg::DATA_W-1:0] FINE_VAL = 32'h5A3C_0F96
) (
    // Clock.
    input wire logic clk,
    // Requests from the bench.
    input wire logic [ctr_pkg::SEL_W-1:0] sel,
    input wire logic level,
    input wire logic noise_en,
    input wire logic sync_lvl,
    // Lines towards the block.
    output logic [ctr_pkg::NUM_LINES-1:0] lines,
    output logic sync_out,
    output logic [ctr_pkg::DATA_W-1:0] fine_cnt
);
    import ctr_pkg::*;
    initial begin
        lines = '0;
        sync_out = 1'b0;
    end
    // The fine count comes from another domain and is simply held.
    assign fine_cnt = FINE_VAL;
    // Unselected lines chatter so that a wrong selection shows as stray events.
    always @(posedge clk) begin
        for (int i = 0; i < NUM_LINES; i++) begin
            lines[i] <= (noise_en && i != int'(sel)) ? 1'($urandom) : level;
        end
        sync_out <= sync_lvl;
    end
endmodule : ctr_cap_src

// *** ctr_capture_timebase.sv ***
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module ctr_capture_timebase (
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RST,
    // Register port.
    input wire logic [ctr_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [ctr_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [ctr_pkg::DATA_W-1:0] REG_RDATA,
    // Capture inputs and timer links.
    input wire logic [ctr_pkg::NUM_LINES-1:0] CAPTURE_INPUT_LINES,
    input wire logic SYNC_IN_PULSE,
    input wire logic DEBUG_SUSPEND,
    input wire logic [ctr_pkg::DATA_W-1:0] FINE_RESOLUTION_COUNT,
    // Event and status outputs.
    output logic [ctr_pkg::NUM_SLOTS-1:0] CAPTURE_EVENT_N,
    output logic COUNTER_OVERFLOW_FLAG,
    output logic [ctr_pkg::PTR_W-1:0] CAPTURE_SLOT_POINTER
);
    import ctr_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] tsc;
        logic [DATA_W-1:0] phase;
        logic [NUM_SLOTS-1:0][DATA_W-1:0] slot;
        logic [SEL_W-1:0] insel;
        logic [EVCTL_W-1:0] evctl;
        logic opmode;
        logic syncen;
        logic run;
        logic hr;
        logic ovf;
        logic [PTR_W-1:0] ptr;
        logic div_prev;
        logic sync_prev;
        logic [NUM_SLOTS-1:0] evt;
        logic [DATA_W-1:0] rdata;
    } ctr_state_t;

    ctr_state_t state_ff;
    ctr_state_t nxt_state;

    logic [NUM_LINES-1:0] lines_sync;
    logic sync_in_sync;
    logic debug_sync;
    logic [DATA_W-1:0] fine_sync;
    logic selected_line;
    logic divided_line;

    // Every capture, sync, debug and fine-count pin passes two flip-flops before any logic reads it; the register port does not.
    ctr_sync #(
        .W(NUM_LINES)
    ) u_sync_lines (
        .clk(CLK_SYS),
        .rst(RST),
        .async_in(CAPTURE_INPUT_LINES),
        .sync_out(lines_sync)
    );

    ctr_sync #(
        .W(1)
    ) u_sync_syncin (
        .clk(CLK_SYS),
        .rst(RST),
        .async_in(SYNC_IN_PULSE),
        .sync_out(sync_in_sync)
    );

    ctr_sync #(
        .W(1)
    ) u_sync_debug (
        .clk(CLK_SYS),
        .rst(RST),
        .async_in(DEBUG_SUSPEND),
        .sync_out(debug_sync)
    );

    // The fine count runs in its own domain; a multi-bit copy can tear, so the
    // value read back is only approximate.
    ctr_sync #(
        .W(DATA_W)
    ) u_sync_fine (
        .clk(CLK_SYS),
        .rst(RST),
        .async_in(FINE_RESOLUTION_COUNT),
        .sync_out(fine_sync)
    );

    assign selected_line = lines_sync[state_ff.insel];

    ctr_prescale u_prescale (
        .clk(CLK_SYS),
        .rst(RST),
        .sig_in(selected_line),
        .div_sel(state_ff.evctl[EV_DIV_LSB +: DIV_W]),
        .sig_out(divided_line)
    );

    always_comb begin
        logic rise;
        logic fall;
        logic pol;
        logic clr_on_evt;
        logic trig;
        logic halt_stop;
        logic cnt_inc;
        logic period_hit;
        logic sync_evt;
        logic sw_sync;
        logic [HALT_W-1:0] halt_mode;
        logic phase_load;
        logic ovf_set;
        logic load_slot;

        rise = 1'b0;
        fall = 1'b0;
        pol = 1'b0;
        clr_on_evt = 1'b0;
        trig = 1'b0;
        halt_stop = 1'b0;
        cnt_inc = 1'b0;
        period_hit = 1'b0;
        sync_evt = 1'b0;
        sw_sync = 1'b0;
        phase_load = 1'b0;
        ovf_set = 1'b0;
        load_slot = 1'b0;
        halt_mode = HALT_STOP;

        nxt_state = state_ff;
        nxt_state.evt = '0;
        nxt_state.rdata = WORD_RST;
        // Both edge detectors reset low, the idle level of their inputs, so no
        // false edge follows reset.
        nxt_state.div_prev = divided_line;
        nxt_state.sync_prev = sync_in_sync;

        // Edge detection runs on the divided signal.
        rise = divided_line && !state_ff.div_prev;
        fall = !divided_line && state_ff.div_prev;
        pol = state_ff.evctl[EV_STRIDE * state_ff.ptr + EV_POL_OFS];
        clr_on_evt = state_ff.evctl[EV_STRIDE * state_ff.ptr + EV_CLR_OFS];
        // Capture events exist only while the block is in capture mode.
        trig = !state_ff.opmode && (pol ? fall : rise);

        // Debug suspend policy.
        // Value 1 stops only while the count sits at zero, so it halts after the wrap.
        halt_mode = state_ff.evctl[EV_HALT_LSB +: HALT_W];
        halt_stop = debug_sync && ((halt_mode == HALT_STOP) ||
                    ((halt_mode == HALT_AT_ZERO) && (state_ff.tsc == WORD_RST)));
        cnt_inc = state_ff.run && !halt_stop;

        period_hit = state_ff.opmode && (state_ff.tsc == state_ff.slot[SLOT_ONE]);
        sync_evt = sync_in_sync && !state_ff.sync_prev;
        sw_sync = REG_WR && (REG_ADDR == OFS_MODE) && REG_WDATA[MODE_SWSYNC_BIT];
        // The enable is the one held before this cycle's mode write, so a write that
        // sets the enable and forces a sync at once does not load the counter.
        phase_load = (sync_evt || sw_sync) && state_ff.syncen && !state_ff.hr;
        ovf_set = cnt_inc && (state_ff.tsc == TSC_MAX);
        load_slot = trig && state_ff.evctl[EV_LDEN_BIT];

        // Counter: the free increment has the lowest priority.
        if (cnt_inc) begin
            nxt_state.tsc = DATA_W'(state_ff.tsc + TSC_STEP);
        end

        // Period boundary in PWM mode clears the counter and moves the shadows
        // into the active slots.
        if (period_hit) begin
            nxt_state.tsc = WORD_RST;
            nxt_state.slot[SLOT_ONE] = state_ff.slot[SLOT_THREE];
            nxt_state.slot[SLOT_TWO] = state_ff.slot[SLOT_FOUR];
        end

        // Software writes.
        if (REG_WR) begin
            unique case (REG_ADDR)
                OFS_TSC: begin
                    if (!state_ff.hr) begin
                        nxt_state.tsc = REG_WDATA;
                    end
                end
                OFS_PHASE: begin
                    nxt_state.phase = REG_WDATA;
                end
                OFS_SLOT_ONE: begin
                    nxt_state.slot[SLOT_ONE] = REG_WDATA;
                    // In PWM mode a write to the active period also primes its shadow.
                    if (state_ff.opmode) begin
                        nxt_state.slot[SLOT_THREE] = REG_WDATA;
                    end
                end
                OFS_SLOT_TWO: begin
                    nxt_state.slot[SLOT_TWO] = REG_WDATA;
                    if (state_ff.opmode) begin
                        nxt_state.slot[SLOT_FOUR] = REG_WDATA;
                    end
                end
                OFS_SLOT_THREE: begin
                    nxt_state.slot[SLOT_THREE] = REG_WDATA;
                end
                OFS_SLOT_FOUR: begin
                    nxt_state.slot[SLOT_FOUR] = REG_WDATA;
                end
                OFS_INSEL: begin
                    nxt_state.insel = REG_WDATA[SEL_W-1:0];
                end
                OFS_EVCTL: begin
                    nxt_state.evctl = REG_WDATA[EVCTL_W-1:0];
                end
                OFS_MODE: begin
                    nxt_state.opmode = REG_WDATA[MODE_OPMODE_BIT];
                    nxt_state.syncen = REG_WDATA[MODE_SYNCEN_BIT];
                    nxt_state.run = REG_WDATA[MODE_RUN_BIT];
                    nxt_state.hr = REG_WDATA[MODE_HR_BIT];
                    // Overflow flag is write-one-to-clear.
                    if (REG_WDATA[MODE_OVF_BIT]) begin
                        nxt_state.ovf = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Overflow is set after the clear so that a wrap in the clearing
        // cycle is never lost.
        if (ovf_set) begin
            nxt_state.ovf = 1'b1;
        end

        // Capture event: record, optionally clear, then advance the pointer.
        if (trig) begin
            nxt_state.evt[state_ff.ptr] = 1'b1;
            if (load_slot) begin
                nxt_state.slot[state_ff.ptr] = state_ff.tsc;
            end
            if (clr_on_evt) begin
                nxt_state.tsc = WORD_RST;
            end
            nxt_state.ptr = PTR_W'(state_ff.ptr + PTR_STEP);
        end

        // Phase load has the highest priority, gated by the enable and by the
        // fine resolution mode.
        if (phase_load) begin
            nxt_state.tsc = state_ff.phase;
        end

        // Read data stands in the cycle after the read strobe only.
        // Reserved bits read zero because the read word starts cleared above.
        if (REG_RD) begin
            unique case (REG_ADDR)
                OFS_TSC: begin
                    nxt_state.rdata = state_ff.hr ? fine_sync : state_ff.tsc;
                end
                OFS_PHASE: begin
                    nxt_state.rdata = state_ff.phase;
                end
                OFS_SLOT_ONE: begin
                    nxt_state.rdata = state_ff.slot[SLOT_ONE];
                end
                OFS_SLOT_TWO: begin
                    nxt_state.rdata = state_ff.slot[SLOT_TWO];
                end
                OFS_SLOT_THREE: begin
                    nxt_state.rdata = state_ff.slot[SLOT_THREE];
                end
                OFS_SLOT_FOUR: begin
                    nxt_state.rdata = state_ff.slot[SLOT_FOUR];
                end
                OFS_INSEL: begin
                    nxt_state.rdata[SEL_W-1:0] = state_ff.insel;
                end
                OFS_EVCTL: begin
                    nxt_state.rdata[EVCTL_W-1:0] = state_ff.evctl;
                end
                OFS_MODE: begin
                    nxt_state.rdata[MODE_OPMODE_BIT] = state_ff.opmode;
                    nxt_state.rdata[MODE_SYNCEN_BIT] = state_ff.syncen;
                    nxt_state.rdata[MODE_RUN_BIT] = state_ff.run;
                    nxt_state.rdata[MODE_OVF_BIT] = state_ff.ovf;
                    nxt_state.rdata[MODE_PTR_LSB +: PTR_W] = state_ff.ptr;
                    nxt_state.rdata[MODE_HR_BIT] = state_ff.hr;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_ff.tsc <= WORD_RST;
            state_ff.phase <= WORD_RST;
            state_ff.slot <= '0;
            // Input select is the one field that leaves reset as all ones.
            state_ff.insel <= INSEL_RST;
            state_ff.evctl <= EVCTL_RST;
            state_ff.opmode <= 1'b0;
            state_ff.syncen <= 1'b0;
            state_ff.run <= 1'b0;
            state_ff.hr <= 1'b0;
            state_ff.ovf <= 1'b0;
            state_ff.ptr <= '0;
            state_ff.div_prev <= 1'b0;
            state_ff.sync_prev <= 1'b0;
            state_ff.evt <= '0;
            state_ff.rdata <= WORD_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign REG_RDATA = state_ff.rdata;
    assign CAPTURE_EVENT_N = state_ff.evt;
    assign COUNTER_OVERFLOW_FLAG = state_ff.ovf;
    assign CAPTURE_SLOT_POINTER = state_ff.ptr;
endmodule : ctr_capture_timebase

// *** ctr_capture_timebase_asserts.sv ***
`timescale 1ns/1ps
module ctr_capture_timebase_asserts (
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RST,
    // Register port.
    input wire logic [ctr_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic [ctr_pkg::DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [ctr_pkg::DATA_W-1:0] REG_RDATA,
    // Capture inputs and timer links.
    input wire logic [ctr_pkg::NUM_LINES-1:0] CAPTURE_INPUT_LINES,
    input wire logic SYNC_IN_PULSE,
    input wire logic DEBUG_SUSPEND,
    input wire logic [ctr_pkg::DATA_W-1:0] FINE_RESOLUTION_COUNT,
    // Event and status outputs.
    input wire logic [ctr_pkg::NUM_SLOTS-1:0] CAPTURE_EVENT_N,
    input wire logic COUNTER_OVERFLOW_FLAG,
    input wire logic [ctr_pkg::PTR_W-1:0] CAPTURE_SLOT_POINTER
);
    import ctr_pkg::*;
    // Tracks the selected line and how long it has been still.
    logic [SEL_W-1:0] sel_ff;
    logic line_ff;
    logic [3:0] quiet_ff;
    wire logic cur_line = CAPTURE_INPUT_LINES[sel_ff];
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sel_ff <= INSEL_RST;
            line_ff <= 1'b0;
            quiet_ff <= 4'h0;
        end else begin
            if (REG_WR && REG_ADDR == OFS_INSEL) begin
                sel_ff <= REG_WDATA[SEL_W-1:0];
            end
            line_ff <= cur_line;
            quiet_ff <= (cur_line != line_ff) ? 4'h0 : quiet_ff + 4'(quiet_ff != 4'hF);
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == WORD_RST)
        else $error("read data without a read");
    a_event_onehot: assert property ($onehot0(CAPTURE_EVENT_N))
        else $error("several capture events at once");
    a_ptr_step: assert property (|CAPTURE_EVENT_N |->
        CAPTURE_SLOT_POINTER == $past(CAPTURE_SLOT_POINTER) + PTR_STEP)
        else $error("pointer did not advance on event");
    a_ptr_hold: assert property (CAPTURE_EVENT_N == 4'h0 |->
        $stable(CAPTURE_SLOT_POINTER))
        else $error("pointer moved without event");
    a_event_slot: assert property (|CAPTURE_EVENT_N |->
        CAPTURE_EVENT_N == 4'(4'h1 << $past(CAPTURE_SLOT_POINTER)))
        else $error("event bit does not match pointer");
    a_ovf_sticky: assert property (COUNTER_OVERFLOW_FLAG &&
        !(REG_WR && REG_ADDR == OFS_MODE && REG_WDATA[MODE_OVF_BIT]) |=> COUNTER_OVERFLOW_FLAG)
        else $error("overflow flag dropped without clear");
    a_event_quiet: assert property (quiet_ff >= 4'h7 |-> CAPTURE_EVENT_N == 4'h0)
        else $error("capture event with a still input");
    a_mode_status: assert property ($past(REG_RD && REG_ADDR == OFS_MODE) |->
        REG_RDATA[6:4] == {$past(CAPTURE_SLOT_POINTER), $past(COUNTER_OVERFLOW_FLAG)})
        else $error("status read disagrees with outputs");
    c_event: cover property (|CAPTURE_EVENT_N);
    c_overflow: cover property ($rose(COUNTER_OVERFLOW_FLAG));
    c_mode_read: cover property (REG_RD && REG_ADDR == OFS_MODE);
endmodule : ctr_capture_timebase_asserts
bind ctr_capture_timebase ctr_capture_timebase_asserts u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .CAPTURE_INPUT_LINES(CAPTURE_INPUT_LINES),
    .SYNC_IN_PULSE(SYNC_IN_PULSE), .DEBUG_SUSPEND(DEBUG_SUSPEND),
    .FINE_RESOLUTION_COUNT(FINE_RESOLUTION_COUNT), .CAPTURE_EVENT_N(CAPTURE_EVENT_N),
    .COUNTER_OVERFLOW_FLAG(COUNTER_OVERFLOW_FLAG), .CAPTURE_SLOT_POINTER(CAPTURE_SLOT_POINTER));

// *** ctr_capture_timebase_bench.sv ***
`timescale 1ns/1ps
module ctr_capture_timebase_bench;
    import ctr_pkg::*;
    localparam logic [DATA_W-1:0] FINE_VAL = 32'h5A3C_0F96;
    logic clk_sys = 1'b0;
    logic rst = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic dbg_susp = 1'b0;
    logic [SEL_W-1:0] m_sel = INSEL_RST;
    logic m_level = 1'b0;
    logic m_noise = 1'b0;
    logic m_sync = 1'b0;
    wire logic [DATA_W-1:0] reg_rdata, fine_cnt;
    wire logic [NUM_LINES-1:0] lines;
    wire logic sync_in, ovf_flag;
    wire logic [NUM_SLOTS-1:0] cap_ev;
    wire logic [PTR_W-1:0] slot_ptr;
    int n_fail = 0;
    int n_checks = 0;
    logic [DATA_W-1:0] exp_rd[$];
    logic [NUM_SLOTS-1:0] exp_ev[$];
    logic [PTR_W-1:0] ptr = '0;
    logic [DATA_W-1:0] slot_v[4] = '{default: '0};
    logic [DATA_W-1:0] v;
    logic rd_d = 1'b0;
    ctr_capture_timebase uut (.CLK_SYS(clk_sys), .RST(rst), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .CAPTURE_INPUT_LINES(lines), .SYNC_IN_PULSE(sync_in), .DEBUG_SUSPEND(dbg_susp),
        .FINE_RESOLUTION_COUNT(fine_cnt), .CAPTURE_EVENT_N(cap_ev),
        .COUNTER_OVERFLOW_FLAG(ovf_flag), .CAPTURE_SLOT_POINTER(slot_ptr));
    ctr_cap_src #(.FINE_VAL(FINE_VAL)) u_src (.clk(clk_sys), .sel(m_sel), .level(m_level),
        .noise_en(m_noise), .sync_lvl(m_sync), .lines(lines), .sync_out(sync_in),
        .fine_cnt(fine_cnt));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wrap_up();
        check(exp_ev.size(), 0);
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_rd.push_back(e);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask : rd
    // Flips the held line and notes the event expected from it, if any.
    task automatic line_to(input logic [NUM_SLOTS-1:0] ev);
        m_level <= ~m_level;
        if (ev != 4'h0) begin
            exp_ev.push_back(ev);
        end
        repeat (8) @(posedge clk_sys);
    endtask : line_to
    task automatic cap_round(input logic lden);
        logic [DATA_W-1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = $urandom;
            wr(OFS_TSC, c);
            if (lden) begin
                slot_v[ptr] = c;
            end
            line_to(4'(4'h1 << ptr));
            ptr++;
            if (i == 1) begin
                rd(OFS_TSC, lden ? WORD_RST : c);
            end
        end
        for (int i = 0; i < 4; i++) begin
            rd(ADDR_W'(OFS_SLOT_ONE + 2 * i), slot_v[i]);
        end
    endtask : cap_round
    always @(posedge clk_sys) begin
        if (rd_d) begin
            check(reg_rdata, exp_rd.pop_front());
        end
        if (cap_ev !== 4'h0) begin
            check(32'(cap_ev), 32'(exp_ev.size() > 0 ? exp_ev.pop_front() : 4'h0));
        end
        rd_d <= reg_rd;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        wrap_up();
    end
    initial begin
        void'($urandom(51));
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (slot_v[i]) rd(ADDR_W'(OFS_SLOT_ONE + 2 * i), WORD_RST);
        rd(OFS_TSC, WORD_RST);
        rd(OFS_INSEL, 32'h0000_007F);
        rd(OFS_EVCTL, WORD_RST);
        rd(5'h1E, WORD_RST);
        for (int i = 0; i < 6; i++) begin
            v = $urandom;
            wr(ADDR_W'(2 * i), v);
            rd(ADDR_W'(2 * i), v);
        end
        v = $urandom;
        m_sel <= v[6:0];
        wr(OFS_INSEL, v | 32'hFFFF_FF80);
        rd(OFS_INSEL, {25'h0, v[6:0]});
        m_noise <= 1'b1;
        wr(OFS_EVCTL, 32'hABCD_014C);
        rd(OFS_EVCTL, 32'h0000_014C);
        cap_round(1'b1);
        wr(OFS_EVCTL, 32'h0000_0044);
        cap_round(1'b0);
        check({30'h0, slot_ptr}, {30'h0, ptr});
        wr(OFS_EVCTL, 32'h0000_0300);
        v = $urandom;
        wr(OFS_TSC, v);
        for (int i = 0; i < 2; i++) begin
            exp_ev.push_back(4'(4'h1 << ptr));
            slot_v[ptr] = v;
            ptr++;
        end
        repeat (8) line_to(4'h0);
        foreach (slot_v[i]) rd(ADDR_W'(OFS_SLOT_ONE + 2 * i), slot_v[i]);
        wr(OFS_MODE, 32'h4);
        dbg_susp <= 1'b1;
        repeat (4) @(posedge clk_sys);
        wr(OFS_TSC, v);
        repeat (10) @(posedge clk_sys);
        rd(OFS_TSC, v);
        wr(OFS_EVCTL, 32'h0000_8000);
        wr(OFS_TSC, 32'h0000_0100);
        rd(OFS_TSC, 32'h0000_0101);
        wr(OFS_EVCTL, 32'h0000_4000);
        wr(OFS_TSC, 32'hFFFF_FFF8);
        repeat (20) @(posedge clk_sys);
        rd(OFS_TSC, WORD_RST);
        check({31'h0, ovf_flag}, 32'h1);
        dbg_susp <= 1'b0;
        wr(OFS_MODE, 32'h12);
        wr(OFS_PHASE, v);
        wr(OFS_MODE, 32'hA);
        rd(OFS_TSC, v);
        wr(OFS_MODE, 32'h0);
        wr(OFS_PHASE, ~v);
        wr(OFS_MODE, 32'h8);
        rd(OFS_TSC, v);
        wr(OFS_MODE, 32'h2);
        m_sync <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rd(OFS_TSC, ~v);
        m_sync <= 1'b0;
        wr(OFS_TSC, 32'hFFFF_FFF0);
        wr(OFS_MODE, 32'h4);
        repeat (30) @(posedge clk_sys);
        check({31'h0, ovf_flag}, 32'h1);
        rd(OFS_MODE, {25'h0, ptr, 5'h14});
        wr(OFS_MODE, 32'h10);
        @(negedge clk_sys);
        check({31'h0, ovf_flag}, 32'h0);
        wr(OFS_TSC, WORD_RST);
        wr(OFS_SLOT_ONE, 32'd20);
        wr(OFS_SLOT_TWO, 32'd5);
        wr(OFS_SLOT_THREE, 32'd30);
        wr(OFS_SLOT_FOUR, 32'd9);
        wr(OFS_MODE, 32'h5);
        repeat (60) @(posedge clk_sys);
        wr(OFS_MODE, 32'h0);
        rd(OFS_SLOT_ONE, 32'd30);
        rd(OFS_SLOT_TWO, 32'd9);
        wr(OFS_TSC, 32'h0000_0007);
        wr(OFS_MODE, 32'h80);
        rd(OFS_TSC, FINE_VAL);
        wr(OFS_TSC, 32'h1);
        rd(OFS_TSC, FINE_VAL);
        wr(OFS_MODE, 32'h0);
        rd(OFS_TSC, 32'h0000_0007);
        m_noise <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b1;
        m_sel <= INSEL_RST;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        rd(OFS_INSEL, 32'h0000_007F);
        rd(OFS_MODE, WORD_RST);
        repeat (3) @(posedge clk_sys);
        wrap_up();
    end
endmodule : ctr_capture_timebase_bench

// *** ctr_pkg.sv ***
package ctr_pkg;

    // Register port geometry.
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int NUM_SLOTS = 4;
    localparam int NUM_LINES = 128;
    localparam int SEL_W = 7;
    localparam int DIV_W = 5;
    localparam int EVCTL_W = 16;
    localparam int PTR_W = 2;
    localparam int HALT_W = 2;

    // Register offsets, in 16-bit word units.
    localparam logic [ADDR_W-1:0] OFS_TSC = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_PHASE = 5'h02;
    localparam logic [ADDR_W-1:0] OFS_SLOT_ONE = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_SLOT_TWO = 5'h06;
    localparam logic [ADDR_W-1:0] OFS_SLOT_THREE = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_SLOT_FOUR = 5'h0A;
    localparam logic [ADDR_W-1:0] OFS_INSEL = 5'h12;
    localparam logic [ADDR_W-1:0] OFS_EVCTL = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_MODE = 5'h1C;

    // Slot indices.
    localparam int SLOT_ONE = 0;
    localparam int SLOT_TWO = 1;
    localparam int SLOT_THREE = 2;
    localparam int SLOT_FOUR = 3;

    // Fields of capture_event_control.
    localparam int EV_POL_OFS = 0;
    localparam int EV_CLR_OFS = 1;
    localparam int EV_STRIDE = 2;
    localparam int EV_LDEN_BIT = 8;
    localparam int EV_DIV_LSB = 9;
    localparam int EV_HALT_LSB = 14;

    // Fields of the mode and status register.
    localparam int MODE_OPMODE_BIT = 0;
    localparam int MODE_SYNCEN_BIT = 1;
    localparam int MODE_RUN_BIT = 2;
    localparam int MODE_SWSYNC_BIT = 3;
    localparam int MODE_OVF_BIT = 4;
    localparam int MODE_PTR_LSB = 5;
    localparam int MODE_HR_BIT = 7;

    // Debug halt encodings.
    localparam logic [HALT_W-1:0] HALT_STOP = 2'h0;
    localparam logic [HALT_W-1:0] HALT_AT_ZERO = 2'h1;

    // Reset values, counter limit and step constants.
    localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] TSC_MAX = 32'hFFFF_FFFF;
    localparam logic [DATA_W-1:0] TSC_STEP = 32'h0000_0001;
    localparam logic [SEL_W-1:0] INSEL_RST = 7'h7F;
    localparam logic [EVCTL_W-1:0] EVCTL_RST = 16'h0000;
    localparam logic [PTR_W-1:0] PTR_STEP = 2'h1;
    localparam logic [DIV_W-1:0] DIV_STEP = 5'h01;
    localparam logic [DIV_W-1:0] DIV_BYPASS = 5'h00;

endpackage : ctr_pkg

// *** ctr_prescale.sv ***
`timescale 1ns/1ps
module ctr_prescale (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Selected input and divider setting.
    input wire logic sig_in,
    input wire logic [ctr_pkg::DIV_W-1:0] div_sel,
    // Divided signal, registered.
    output logic sig_out
);
    import ctr_pkg::*;

    typedef struct packed {
        logic prev;
        logic [DIV_W-1:0] cnt;
        logic tog;
        logic out;
    } ctr_presc_t;

    ctr_presc_t state_ff;
    ctr_presc_t nxt_state;

    // The output toggles every div_sel rising edges, so one output period spans
    // 2*div_sel input periods; zero passes the input straight through.
    always_comb begin
        nxt_state = state_ff;
        nxt_state.prev = sig_in;
        if (div_sel == DIV_BYPASS) begin
            nxt_state.cnt = DIV_BYPASS;
            nxt_state.tog = sig_in;
            nxt_state.out = sig_in;
        end else begin
            if (sig_in && !state_ff.prev) begin
                if (DIV_W'(state_ff.cnt + DIV_STEP) >= div_sel) begin
                    nxt_state.cnt = DIV_BYPASS;
                    nxt_state.tog = !state_ff.tog;
                end else begin
                    nxt_state.cnt = DIV_W'(state_ff.cnt + DIV_STEP);
                end
            end
            nxt_state.out = nxt_state.tog;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sig_out = state_ff.out;
endmodule : ctr_prescale

// *** ctr_sync.sv ***
`timescale 1ns/1ps
module ctr_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Signals from another domain and their synchronised copy.
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } ctr_sync_t;

    ctr_sync_t state_ff;
    ctr_sync_t nxt_state;

    always_comb begin
        nxt_state.meta = async_in;
        nxt_state.stable = state_ff.meta;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sync_out = state_ff.stable;
endmodule : ctr_sync
